//--- pkg/opc_consts.svh
`ifndef OPC_CONSTS_SVH
`define OPC_CONSTS_SVH
// Functional notes
// (R1) stop-key policy applies only when run source is not the keypad (02)
// (R2) keypad run source: stop key always stops and resets trips
// (R3) stop-key policy 00 both enabled, 01 both off, 02 reset only
// (R4) any terminal with function 15 acts as the write-lock input
// (R5) lock mode 00: lock input on rejects all but lock-mode writes
// (R6) lock mode 01: lock input on also exempts setpoint, multispeed, jog
// (R7) modes 02/03 lock always; 03 also exempts setpoint, multispeed, jog
// (R8) lock mode 10 allows parameter edits while the drive runs
// (R9) panel copy policy 00 allows panel read/copy, 01 refuses it
// (R10) force-keypad input on takes frequency and run from the keypad
// (R11) terminal function 31 is the force-keypad input
// (R12) source change while running cancels the run and stops output
// (R13) other party drops every run command, then issues a fresh one
// (R14) force-terminal input on takes commands from the terminal block
// (R15) terminal function 51 is the force-terminal input
// (R16) force-keypad wins when both force inputs are on
// (R17) panel link lost after five seconds without communication
// (R18) link-loss action: trip, decel-trip, ignore, coast, decel
// (R19) power-on screen: 000 last set code, 001-060 monitor, 201 setpoint
// (R20) power-on selection 202 behaves like 000 on a digital keypad
// (R21) power-on screen falls back to the first monitor item, 01
// (R22) last set-confirmed code is kept across power loss
// (R23) rejected parameter write leaves the stored value unchanged

// ****************************************
// sizes and timing
// ****************************************
`define OPC_N_TERM 5
`define OPC_CLK_HZ 32'h05f5_e100
`define OPC_LINK_LOSS_S 32'h0000_0005
`define OPC_LINK_LOSS_CYC (`OPC_LINK_LOSS_S * `OPC_CLK_HZ)

// ****************************************
// setting codes
// ****************************************
`define OPC_SRC_TERM 8'h01
`define OPC_SRC_KEYPAD 8'h02
`define OPC_STOP_BOTH 8'h00
`define OPC_STOP_NONE 8'h01
`define OPC_STOP_RESET 8'h02
`define OPC_FN_LOCK 8'h15
`define OPC_FN_FKEY 8'h31
`define OPC_FN_FTERM 8'h51
`define OPC_LOCK_M0 8'h00
`define OPC_LOCK_M1 8'h01
`define OPC_LOCK_M2 8'h02
`define OPC_LOCK_M3 8'h03
`define OPC_LOCK_RUN 8'h10
`define OPC_COPY_OK 8'h00
`define OPC_LOSS_TRIP 8'h00
`define OPC_LOSS_DTRIP 8'h01
`define OPC_LOSS_COAST 8'h03
`define OPC_LOSS_DECEL 8'h04
`define OPC_LINK_TRIP_CODE 8'h40
`define OPC_SCR_LAST 12'h000
`define OPC_SCR_MON_LO 12'h001
`define OPC_SCR_MON_HI 12'h060
`define OPC_SCR_SETP 12'h201
`define OPC_SCR_LCDB 12'h202
`define OPC_SCR_DEF_MON 16'h0001

// ****************************************
// parameter item ids
// ****************************************
`define OPC_ID_LOCK 16'h0001
`define OPC_ID_SETP 16'h0010
`define OPC_ID_MS_BASE 16'h0020
`define OPC_ID_MS_BASE2 16'h0021
`define OPC_ID_MS_LO 16'h0022
`define OPC_ID_MS_HI 16'h0028
`define OPC_ID_JOG 16'h0030
`endif

//--- pkg/opc_pkg.sv
package opc_pkg;
    // configuration settings
    typedef struct packed {
        logic [7:0] stop_key_policy;
        logic [7:0] run_command_source;
        logic [7:0] frequency_command_source;
        logic [7:0] write_lock_mode;
        logic [7:0] panel_copy_policy;
        logic [7:0] panel_link_loss_action;
        logic [11:0] power_on_screen_select;
    } opc_cfg_s;
    // command from one source
    typedef struct packed {
        logic run;
        logic [15:0] freq;
    } opc_cmd_s;
    // parameter write
    typedef struct packed {
        logic valid;
        logic [15:0] id;
        logic [15:0] data;
    } opc_wr_s;
    typedef enum logic [1:0] {
        opc_scr_last,
        opc_scr_monitor,
        opc_scr_setpoint
    } opc_screen_e;
    typedef enum logic [1:0] {
        opc_lk_ok,
        opc_lk_decel,
        opc_lk_lost
    } opc_link_e;
endpackage

//--- verilog/opc_sync.sv
`timescale 1ns/1ps
module opc_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    generate
        if (W < 1) begin : g_chk
            $error("opc_sync width must be at least one");
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule

//--- verilog/opc_top.sv
`timescale 1ns/1ps
`include "opc_consts.svh"
module opc_top #(
    parameter int unsigned N_TERM = `OPC_N_TERM,
    parameter int unsigned LINK_LOSS_CYC = `OPC_LINK_LOSS_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // settings
    input wire opc_pkg::opc_cfg_s cfg,
    input wire logic [N_TERM-1:0][7:0] input_terminal_function,
    // pins
    input wire logic [N_TERM-1:0] term_pin,
    input wire logic stop_key_pin,
    // command sources
    input wire opc_pkg::opc_cmd_s keypad_cmd,
    input wire opc_pkg::opc_cmd_s terminal_cmd,
    input wire opc_pkg::opc_cmd_s other_cmd,
    // drive state
    input wire logic drive_running,
    input wire logic drive_tripped,
    // parameter store
    input wire opc_pkg::opc_wr_s wr_req,
    output opc_pkg::opc_wr_s param_wr,
    output logic wr_reject,
    // panel link
    input wire logic panel_heard,
    input wire logic copy_req,
    output logic copy_ok,
    output logic copy_deny,
    // drive commands
    output opc_pkg::opc_cmd_s cmd_out,
    output logic [7:0] run_src_eff,
    output logic stop_cmd,
    output logic trip_reset,
    // link loss
    output logic link_lost,
    output logic link_trip,
    output logic [7:0] trip_code,
    output logic decel_stop,
    output logic coast_stop,
    // power-on screen
    input wire logic [15:0] nv_last_code,
    output opc_pkg::opc_screen_e screen_kind,
    output logic [15:0] screen_code,
    output logic screen_valid,
    output logic nv_save,
    output logic [15:0] nv_code
);
    localparam int unsigned CW = $clog2(LINK_LOSS_CYC + 1);

    generate
        if (N_TERM < 1 || N_TERM > 8 || LINK_LOSS_CYC < 2) begin : g_chk
            $error("opc_top parameters out of range");
        end
    endgenerate

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [N_TERM:0] pin_s;
    logic key_q_ff;
    logic key_rise;

    opc_sync #(
        .W(N_TERM + 1)
    ) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .d({stop_key_pin, term_pin}),
        .q(pin_s)
    );

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            key_q_ff <= 1'b0;
        end else begin
            key_q_ff <= pin_s[N_TERM];
        end
    end

    assign key_rise = pin_s[N_TERM] && !key_q_ff;

    // ****************************************
    // terminal function decode
    // ****************************************
    logic [N_TERM-1:0] lock_hit;
    logic [N_TERM-1:0] fkey_hit;
    logic [N_TERM-1:0] fterm_hit;
    logic lock_in;
    logic fkey_in;
    logic fterm_in;

    genvar gi;
    generate
        for (gi = 0; gi < N_TERM; gi++) begin : g_term
            assign lock_hit[gi] = pin_s[gi] && input_terminal_function[gi] == `OPC_FN_LOCK; // R4
            assign fkey_hit[gi] = pin_s[gi] && input_terminal_function[gi] == `OPC_FN_FKEY; // R11
            assign fterm_hit[gi] = pin_s[gi] && input_terminal_function[gi] == `OPC_FN_FTERM; // R15
        end
    endgenerate

    assign lock_in = |lock_hit;
    assign fkey_in = |fkey_hit;
    assign fterm_in = |fterm_hit;

    // ****************************************
    // command source selection
    // ****************************************
    logic [7:0] nxt_run_src;
    logic [7:0] nxt_freq_src;
    logic [7:0] run_src_ff;
    logic [7:0] freq_src_ff;
    logic src_switch;
    logic block_ff;
    opc_pkg::opc_cmd_s sel_cmd;
    opc_pkg::opc_cmd_s cmd_ff;

    always_comb begin
        if (fkey_in) begin // R16
            nxt_run_src = `OPC_SRC_KEYPAD; // R10
            nxt_freq_src = `OPC_SRC_KEYPAD;
        end else if (fterm_in) begin
            nxt_run_src = `OPC_SRC_TERM; // R14
            nxt_freq_src = `OPC_SRC_TERM;
        end else begin
            nxt_run_src = cfg.run_command_source;
            nxt_freq_src = cfg.frequency_command_source;
        end
    end

    always_comb begin
        sel_cmd = other_cmd;
        if (nxt_run_src == `OPC_SRC_KEYPAD) begin
            sel_cmd.run = keypad_cmd.run;
        end else if (nxt_run_src == `OPC_SRC_TERM) begin
            sel_cmd.run = terminal_cmd.run;
        end
        if (nxt_freq_src == `OPC_SRC_KEYPAD) begin
            sel_cmd.freq = keypad_cmd.freq;
        end else if (nxt_freq_src == `OPC_SRC_TERM) begin
            sel_cmd.freq = terminal_cmd.freq;
        end
    end

    assign src_switch = nxt_run_src != run_src_ff || nxt_freq_src != freq_src_ff;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            run_src_ff <= `OPC_SRC_TERM;
            freq_src_ff <= `OPC_SRC_TERM;
        end else begin
            run_src_ff <= nxt_run_src;
            freq_src_ff <= nxt_freq_src;
        end
    end

    // ****************************************
    // stop key
    // ****************************************
    logic stop_en;
    logic reset_en;
    logic stop_ff;
    logic trip_reset_ff;

    always_comb begin
        if (nxt_run_src == `OPC_SRC_KEYPAD) begin
            stop_en = 1'b1; // R2
            reset_en = 1'b1;
        end else begin
            stop_en = cfg.stop_key_policy == `OPC_STOP_BOTH; // R1 R3
            reset_en = cfg.stop_key_policy == `OPC_STOP_BOTH || cfg.stop_key_policy == `OPC_STOP_RESET; // R3
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            stop_ff <= 1'b0;
            trip_reset_ff <= 1'b0;
        end else begin
            stop_ff <= key_rise && stop_en;
            trip_reset_ff <= key_rise && reset_en && drive_tripped;
        end
    end

    // ****************************************
    // run cancel and command output
    // ****************************************
    logic loss_hold;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            block_ff <= 1'b0;
        end else if ((src_switch && drive_running) || (key_rise && stop_en)) begin
            block_ff <= 1'b1; // R12
        end else if (!sel_cmd.run) begin
            block_ff <= 1'b0; // R13
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cmd_ff <= '0;
        end else begin
            cmd_ff.freq <= sel_cmd.freq;
            cmd_ff.run <= sel_cmd.run && !block_ff && !loss_hold && !src_switch && !(key_rise && stop_en); // R12
        end
    end

    // ****************************************
    // parameter write lock
    // ****************************************
    logic is_lock_id;
    logic is_freq_id;
    logic locked;
    logic run_block;
    logic wr_ok;
    opc_pkg::opc_wr_s wr_ff;
    logic wr_rej_ff;
    logic nv_save_ff;
    logic [15:0] nv_code_ff;

    assign is_lock_id = wr_req.id == `OPC_ID_LOCK;
    assign is_freq_id = wr_req.id == `OPC_ID_SETP || wr_req.id == `OPC_ID_MS_BASE || wr_req.id == `OPC_ID_MS_BASE2
        || (wr_req.id >= `OPC_ID_MS_LO && wr_req.id <= `OPC_ID_MS_HI) || wr_req.id == `OPC_ID_JOG;

    always_comb begin
        unique case (cfg.write_lock_mode)
            `OPC_LOCK_M0: locked = lock_in; // R5
            `OPC_LOCK_M1: locked = lock_in && !is_freq_id; // R6
            `OPC_LOCK_M2: locked = 1'b1; // R7
            `OPC_LOCK_M3: locked = !is_freq_id; // R7
            default: locked = 1'b0;
        endcase
    end

    assign run_block = drive_running && cfg.write_lock_mode != `OPC_LOCK_RUN && !is_freq_id; // R8
    assign wr_ok = is_lock_id || (!locked && !run_block);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wr_ff <= '0;
            wr_rej_ff <= 1'b0;
        end else begin
            wr_ff.valid <= wr_req.valid && wr_ok; // R23
            wr_ff.id <= wr_req.id;
            wr_ff.data <= wr_req.data;
            wr_rej_ff <= wr_req.valid && !wr_ok;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            nv_save_ff <= 1'b0;
            nv_code_ff <= '0;
        end else begin
            nv_save_ff <= wr_req.valid && wr_ok; // R22
            if (wr_req.valid && wr_ok) begin
                nv_code_ff <= wr_req.id;
            end
        end
    end

    // ****************************************
    // panel copy permission
    // ****************************************
    logic copy_ok_ff;
    logic copy_deny_ff;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            copy_ok_ff <= 1'b0;
            copy_deny_ff <= 1'b0;
        end else begin
            copy_ok_ff <= copy_req && cfg.panel_copy_policy == `OPC_COPY_OK; // R9
            copy_deny_ff <= copy_req && cfg.panel_copy_policy != `OPC_COPY_OK;
        end
    end

    // ****************************************
    // panel link watchdog
    // ****************************************
    logic [CW-1:0] link_cnt_ff;
    logic lost_ff;
    opc_pkg::opc_link_e lk_ff;
    logic trip_ff;
    logic nxt_trip;
    logic [7:0] trip_code_ff;
    logic decel_ff;
    logic coast_ff;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            link_cnt_ff <= '0;
            lost_ff <= 1'b0;
        end else if (panel_heard) begin
            link_cnt_ff <= '0;
            lost_ff <= 1'b0;
        end else if (link_cnt_ff != CW'(LINK_LOSS_CYC)) begin
            link_cnt_ff <= link_cnt_ff + 1'b1;
            lost_ff <= link_cnt_ff == CW'(LINK_LOSS_CYC - 1); // R17
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            lk_ff <= opc_pkg::opc_lk_ok;
        end else begin
            unique case (lk_ff)
                opc_pkg::opc_lk_ok: begin
                    if (lost_ff && cfg.panel_link_loss_action == `OPC_LOSS_DTRIP) begin
                        lk_ff <= opc_pkg::opc_lk_decel; // R18
                    end else if (lost_ff) begin
                        lk_ff <= opc_pkg::opc_lk_lost;
                    end
                end
                opc_pkg::opc_lk_decel: begin
                    if (!drive_running) begin
                        lk_ff <= opc_pkg::opc_lk_lost;
                    end
                end
                opc_pkg::opc_lk_lost: begin
                    if (!lost_ff) begin
                        lk_ff <= opc_pkg::opc_lk_ok;
                    end
                end
            endcase
        end
    end

    // decel-then-trip keeps the trip standing once the drive has stopped
    assign nxt_trip = (lost_ff && cfg.panel_link_loss_action == `OPC_LOSS_TRIP)
        || (lk_ff == opc_pkg::opc_lk_decel && !drive_running)
        || (lk_ff == opc_pkg::opc_lk_lost && lost_ff && cfg.panel_link_loss_action == `OPC_LOSS_DTRIP); // R18

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            trip_ff <= 1'b0;
            trip_code_ff <= '0;
            decel_ff <= 1'b0;
            coast_ff <= 1'b0;
        end else begin
            trip_ff <= nxt_trip; // R18
            trip_code_ff <= nxt_trip ? `OPC_LINK_TRIP_CODE : '0;
            decel_ff <= lost_ff && (cfg.panel_link_loss_action == `OPC_LOSS_DECEL
                || (cfg.panel_link_loss_action == `OPC_LOSS_DTRIP && lk_ff != opc_pkg::opc_lk_lost));
            coast_ff <= lost_ff && cfg.panel_link_loss_action == `OPC_LOSS_COAST;
        end
    end

    assign loss_hold = trip_ff || decel_ff || coast_ff;

    // ****************************************
    // power-on screen
    // ****************************************
    logic scr_done_ff;
    opc_pkg::opc_screen_e scr_kind_ff;
    logic [15:0] scr_code_ff;
    logic [11:0] sel;

    assign sel = cfg.power_on_screen_select;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            scr_done_ff <= 1'b0;
            scr_kind_ff <= opc_pkg::opc_scr_monitor;
            scr_code_ff <= `OPC_SCR_DEF_MON; // R21
        end else if (!scr_done_ff) begin
            scr_done_ff <= 1'b1;
            if (sel == `OPC_SCR_LAST || sel == `OPC_SCR_LCDB) begin
                scr_kind_ff <= opc_pkg::opc_scr_last; // R20 R22
                scr_code_ff <= nv_last_code;
            end else if (sel >= `OPC_SCR_MON_LO && sel <= `OPC_SCR_MON_HI) begin
                scr_kind_ff <= opc_pkg::opc_scr_monitor; // R19
                scr_code_ff <= {4'h0, sel};
            end else if (sel == `OPC_SCR_SETP) begin
                scr_kind_ff <= opc_pkg::opc_scr_setpoint;
                scr_code_ff <= `OPC_ID_SETP;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign param_wr = wr_ff;
    assign wr_reject = wr_rej_ff;
    assign copy_ok = copy_ok_ff;
    assign copy_deny = copy_deny_ff;
    assign cmd_out = cmd_ff;
    assign run_src_eff = run_src_ff;
    assign stop_cmd = stop_ff;
    assign trip_reset = trip_reset_ff;
    assign link_lost = lost_ff;
    assign link_trip = trip_ff;
    assign trip_code = trip_code_ff;
    assign decel_stop = decel_ff;
    assign coast_stop = coast_ff;
    assign screen_kind = scr_kind_ff;
    assign screen_code = scr_code_ff;
    assign screen_valid = scr_done_ff;
    assign nv_save = nv_save_ff;
    assign nv_code = nv_code_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence key_off_keypad;
        key_rise && nxt_run_src != `OPC_SRC_KEYPAD;
    endsequence

    stop_policy_a: assert property (key_off_keypad ##0 cfg.stop_key_policy == `OPC_STOP_NONE // R3
        |=> !stop_ff && !trip_reset_ff) else $error("stop key acted while disabled");
    keypad_stop_a: assert property (key_rise && nxt_run_src == `OPC_SRC_KEYPAD // R2
        |=> stop_ff ##1 !cmd_ff.run) else $error("keypad stop key ignored");
    lock_always_a: assert property (wr_req.valid && cfg.write_lock_mode == `OPC_LOCK_M2 && !is_lock_id // R7
        |=> wr_rej_ff && !wr_ff.valid) else $error("write passed in lock mode 02");
    lock_input_a: assert property (wr_req.valid && cfg.write_lock_mode == `OPC_LOCK_M0 && lock_in // R5
        |=> wr_ff.valid == $past(is_lock_id)) else $error("lock input mode 00 wrong");
    copy_refuse_a: assert property (copy_req && cfg.panel_copy_policy != `OPC_COPY_OK // R9
        |=> copy_deny_ff && !copy_ok_ff) else $error("panel copy not refused");
    force_prio_a: assert property (fkey_in && fterm_in // R16
        |=> run_src_ff == `OPC_SRC_KEYPAD && freq_src_ff == `OPC_SRC_KEYPAD) else $error("force keypad lost");
    switch_cancel_a: assert property (src_switch && drive_running // R12
        |=> !cmd_ff.run ##1 (!cmd_ff.run || !$past(sel_cmd.run))) else $error("run kept over switch");
    link_timeout_a: assert property (link_cnt_ff == CW'(LINK_LOSS_CYC - 1) && !panel_heard // R17
        |=> lost_ff [*2] or (lost_ff ##1 !lost_ff)) else $error("link loss not declared");
    loss_trip_a: assert property (lost_ff && cfg.panel_link_loss_action == `OPC_LOSS_TRIP // R18
        |=> trip_ff && trip_code == `OPC_LINK_TRIP_CODE) else $error("link loss trip missing");
    screen_setp_a: assert property ($rose(scr_done_ff) && $past(sel) == `OPC_SCR_SETP // R19
        |-> scr_kind_ff == opc_pkg::opc_scr_setpoint) else $error("setpoint screen not chosen");
endmodule

//--- testbench/opc_panel_model.sv
`timescale 1ns/1ps
module opc_panel_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // bench control
    input wire logic hb_en,
    input wire logic key,
    input wire logic krun,
    // to the block
    output opc_pkg::opc_cmd_s keypad_cmd,
    output logic stop_key_pin,
    output logic panel_heard
);
    // ****************************************
    // heartbeat, stop key, keypad command
    // ****************************************
    logic [3:0] hb_ff;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            hb_ff <= 4'h0;
        end else begin
            hb_ff <= hb_ff + 4'h1;
        end
    end
    assign panel_heard = hb_en && (hb_ff == 4'hf);
    assign stop_key_pin = key;
    assign keypad_cmd = '{run: krun, freq: 16'h0222};
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 0;
    logic resetn = 0;
    opc_pkg::opc_cfg_s cfg = '0;
    logic [4:0][7:0] input_terminal_function = {8'h00, 8'h00, 8'h15, 8'h51, 8'h31};
    logic [4:0] term_pin = '0;
    logic hb_en = 1, key = 0, krun = 1, drive_running = 0, drive_tripped = 0, copy_req = 0;
    opc_pkg::opc_cmd_s terminal_cmd = '{run: 1'b1, freq: 16'h0333};
    opc_pkg::opc_cmd_s other_cmd = '{run: 1'b1, freq: 16'h0111};
    opc_pkg::opc_cmd_s keypad_cmd, cmd_out;
    opc_pkg::opc_wr_s wr_req = '0, param_wr;
    opc_pkg::opc_screen_e screen_kind;
    logic [15:0] nv_last_code = 16'h0abc, screen_code, nv_code;
    logic [7:0] run_src_eff, trip_code;
    logic stop_key_pin, panel_heard, wr_reject, copy_ok, copy_deny, stop_cmd, trip_reset;
    logic link_lost, link_trip, decel_stop, coast_stop, screen_valid, nv_save;
    int n_errors = 0, n_compared = 0, n_stop = 0, n_trst = 0;

    opc_top #(.N_TERM(5), .LINK_LOSS_CYC(50)) i_opc_top (.ref_clk, .resetn, .cfg, .input_terminal_function,
        .term_pin, .stop_key_pin, .keypad_cmd, .terminal_cmd, .other_cmd, .drive_running, .drive_tripped,
        .wr_req, .param_wr, .wr_reject, .panel_heard, .copy_req, .copy_ok, .copy_deny, .cmd_out, .run_src_eff,
        .stop_cmd, .trip_reset, .link_lost, .link_trip, .trip_code, .decel_stop, .coast_stop, .nv_last_code,
        .screen_kind, .screen_code, .screen_valid, .nv_save, .nv_code);
    opc_panel_model i_opc_panel_model (.ref_clk, .resetn, .hb_en, .key, .krun, .keypad_cmd, .stop_key_pin,
        .panel_heard);

    // ****************************************
    // clock, counters, shared tasks
    // ****************************************
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        n_stop += int'(stop_cmd === 1'b1);
        n_trst += int'(trip_reset === 1'b1);
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task rst(input logic [11:0] s, input logic [15:0] kind, input logic [15:0] code);
        @(posedge ref_clk);
        resetn <= 0;
        cfg.power_on_screen_select <= s;
        cyc(3);
        resetn <= 1;
        cyc(2);
        #1;
        chk(screen_valid, 1);
        chk(screen_kind, kind);
        chk(screen_code, code);
    endtask
    task lk(input logic [7:0] m, input logic p, input logic r, input logic [15:0] id, input logic ok);
        @(posedge ref_clk);
        cfg.write_lock_mode <= m;
        term_pin[2] <= p;
        drive_running <= r;
        cyc(5);
        wr_req <= '{valid: 1'b1, id: id, data: 16'h5a5a};
        @(posedge ref_clk);
        wr_req.valid <= 1'b0;
        #1;
        chk(param_wr.valid, ok);
        chk(wr_reject, !ok);
        chk(nv_save, ok);
        if (ok) chk(nv_code, id);
    endtask
    task cp(input logic [7:0] pol, input logic ok);
        @(posedge ref_clk);
        cfg.panel_copy_policy <= pol;
        copy_req <= 1;
        @(posedge ref_clk);
        copy_req <= 0;
        #1;
        chk(copy_ok, ok);
        chk(copy_deny, !ok);
    endtask
    task sk(input logic [7:0] pol, input logic [7:0] src, input logic es, input logic et);
        @(posedge ref_clk);
        cfg.stop_key_policy <= pol;
        cfg.run_command_source <= src;
        drive_tripped <= 1;
        cyc(4);
        n_stop = 0;
        n_trst = 0;
        key <= 1;
        cyc(6);
        key <= 0;
        cyc(5);
        chk(16'(n_stop), 16'(es));
        chk(16'(n_trst), 16'(et));
    endtask
    task ll(input logic [7:0] act, input logic [2:0] exp);
        @(posedge ref_clk);
        cfg.panel_link_loss_action <= act;
        drive_running <= 1;
        hb_en <= 1;
        cyc(20);
        hb_en <= 0;
        cyc(30);
        #1;
        chk(link_lost, 0);
        cyc(30);
        #1;
        chk(link_lost, 1);
        chk({link_trip, decel_stop, coast_stop}, exp);
        chk(trip_code, exp[2] ? 8'h40 : 8'h00);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_src;
        @(posedge ref_clk);
        cfg.run_command_source <= 8'h05;
        cfg.frequency_command_source <= 8'h05;
        cyc(5);
        chk(run_src_eff, 8'h05);
        chk(cmd_out.freq, 16'h0111);
        term_pin[0] <= 1;
        cyc(5);
        chk(run_src_eff, 8'h02);
        chk(cmd_out.freq, 16'h0222);
        term_pin[1] <= 1;
        cyc(5);
        chk(run_src_eff, 8'h02);
        term_pin[0] <= 0;
        cyc(5);
        chk(run_src_eff, 8'h01);
        chk(cmd_out.freq, 16'h0333);
        drive_running <= 1;
        term_pin[1] <= 0;
        cyc(5);
        chk(cmd_out.run, 0);
        other_cmd.run <= 0;
        cyc(3);
        other_cmd.run <= 1;
        cyc(3);
        chk(cmd_out.run, 1);
        drive_running <= 0;
        $display("test sources done");
    endtask

    task results;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        results();
    end

    initial begin
        rst(12'h000, opc_pkg::opc_scr_last, 16'h0abc);
        rst(12'h202, opc_pkg::opc_scr_last, 16'h0abc);
        rst(12'h060, opc_pkg::opc_scr_monitor, 16'h0060);
        rst(12'h201, opc_pkg::opc_scr_setpoint, 16'h0010);
        rst(12'h999, opc_pkg::opc_scr_monitor, 16'h0001);
        $display("test screen done");
        lk(8'h00, 1, 0, 16'h0001, 1);
        lk(8'h00, 1, 0, 16'h0040, 0);
        lk(8'h00, 0, 0, 16'h0040, 1);
        lk(8'h01, 1, 0, 16'h0010, 1);
        lk(8'h01, 1, 0, 16'h0021, 1);
        lk(8'h01, 1, 0, 16'h0022, 1);
        lk(8'h01, 1, 0, 16'h0030, 1);
        lk(8'h01, 1, 0, 16'h0040, 0);
        lk(8'h02, 0, 0, 16'h0010, 0);
        lk(8'h02, 0, 0, 16'h0001, 1);
        lk(8'h03, 0, 0, 16'h0030, 1);
        lk(8'h03, 0, 0, 16'h0040, 0);
        lk(8'h10, 0, 1, 16'h0040, 1);
        lk(8'h00, 0, 1, 16'h0040, 0);
        $display("test write lock done");
        cp(8'h00, 1);
        cp(8'h01, 0);
        $display("test copy done");
        t_src();
        sk(8'h00, 8'h01, 1, 1);
        sk(8'h01, 8'h01, 0, 0);
        sk(8'h02, 8'h01, 0, 1);
        sk(8'h01, 8'h02, 1, 1);
        $display("test stop key done");
        ll(8'h00, 3'b100);
        ll(8'h02, 3'b000);
        ll(8'h03, 3'b001);
        ll(8'h04, 3'b010);
        ll(8'h01, 3'b010);
        drive_running <= 0;
        cyc(4);
        chk(link_trip, 1);
        $display("test link loss done");
        results();
    end
endmodule
